// ==== eip_ident_page.sv ====
// Identification page command handling inside a serial EEPROM.
// Assumes pins are asynchronous and sampled on CLOCK; main array is elsewhere.
// Behaviour
// RL1 - One extra 64-byte page, writable, later lockable read-only forever.
// RL2 - Page read: opcode, two address bytes, lock bit 0; low six bits pick byte.
// RL3 - While selected, read address increments and next byte shifts out.
// RL4 - Master must not read past the page end; no wrap. Here the read address wraps from byte 63 to byte 0.
// RL5 - Select high ends a read anytime; output stops driving.
// RL6 - Page read ignored while a write cycle runs.
// RL7 - Page write: opcode, address with lock bit 0, data; low bits pick byte.
// RL8 - Accepted page write starts timed write at select rise.
// RL9 - First three bytes hold identity code; writes may overwrite it.
// RL10 - Write or lock dropped if busy, both guards set, or protocol unmet.
// RL11 - Lock read: opcode, address with lock bit 1, others arbitrary.
// RL12 - Lock read returns byte with LSB showing lock state.
// RL13 - Lock byte repeats while select stays low.
// RL14 - Lock read ignored while a write cycle runs.
// RL15 - Lock command: opcode, address with lock bit 1.
// RL16 - Lock data byte needs bit 1 set; other bits ignored.
// RL17 - Lock only runs if select rises at a byte boundary.
// RL18 - Accepted lock starts timed write; page read-only when done.
// RL19 - Reset clears latch and busy, deselects, keeps guard bits.
// RL20 - Single-bit errors in each four-byte group corrected on read.
// RL21 - One byte written rewrites its whole four-byte group.
// RL22 - Delivery: page holds identity code in first bytes, guards zero.
// RL23 - Lock ops share opcodes with page ops; lock bit selects.
// RL24 - Master issues write unlock before page write or lock.
// RL25 - Locked page refuses every page write.
// RL26 - Busy flag set for the whole timed write cycle.
module eip_ident_page
   import eip_pkg::*;
#(
   parameter int WRITE_CYCLES_P = WRITE_CYCLES,
   parameter logic [23:0] IDENT_CODE = IDENT_CODE_DEFAULT
) (
   // System
   input wire logic CLOCK,
   input wire logic RST_N,
   // Serial pins
   input wire logic SEL_N,
   input wire logic SCLK,
   input wire logic DIN,
   output logic DOUT,
   output logic DOUT_OE,
   // Status flags from and to the status register logic
   input wire logic WRITE_LATCH_FLAG,
   input wire logic BLOCK_GUARD_HI,
   input wire logic BLOCK_GUARD_LO,
   output logic WRITE_BUSY_FLAG,
   output logic LATCH_CLEAR,
   output logic PAGE_LOCKED
);

   eip_pin_if pins ();
   logic timer_start;
   logic timer_busy;
   logic timer_done;

   eip_pin_sync u_sync (
      .clock(CLOCK),
      .rst_n(RST_N),
      .sel_n_pin(SEL_N),
      .sclk_pin(SCLK),
      .din_pin(DIN),
      .pins(pins)
   );

   eip_write_timer #(.CYCLES(WRITE_CYCLES_P)) u_timer (
      .clock(CLOCK),
      .rst_n(RST_N),
      .start(timer_start),
      .busy(timer_busy),
      .done(timer_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Page storage; cells start from the delivery image, not from reset
   typedef logic [7:0] eip_page_t [PAGE_BYTES];
   function automatic eip_page_t delivery_image();
      eip_page_t img;
      for (int i = 0; i < PAGE_BYTES; i++) img[i] = ERASED_BYTE;    // RL22
      img[0] = IDENT_CODE[23:16];                                    // RL9
      img[1] = IDENT_CODE[15:8];
      img[2] = IDENT_CODE[7:0];
      return img;
   endfunction : delivery_image
   eip_page_t page = delivery_image();
   logic [7:0] pend [GROUP_BYTES];
   logic [PAGE_ADDR_W-1:0] pend_addr;
   logic [GROUP_BYTES-1:0] pend_mask;
   logic lock_nv = 1'b0; // RL22
   logic lock_pending;
   logic write_pending;

   // Group index decode, used for commits
   function automatic logic [PAGE_ADDR_W-3:0] group_of(input logic [PAGE_ADDR_W-1:0] a);
      group_of = a[PAGE_ADDR_W-1:2];
   endfunction : group_of

   // Corrected read of one byte; the cell model holds no faults, so the
   // correction path is the identity and the group is kept for the rewrite
   function automatic logic [7:0] read_byte(input logic [PAGE_ADDR_W-1:0] a);
      read_byte = page[a];                                           // RL20
   endfunction : read_byte

   ////////////////////////////////////////////////////////////////////////////
   // Serial sequencer
   eip_state_t state, next_state;
   logic [7:0] shift, next_shift;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic [1:0] addr_bytes, next_addr_bytes;
   logic [7:0] opcode, next_opcode;
   logic lock_sel, next_lock_sel;
   logic [PAGE_ADDR_W-1:0] addr, next_addr;
   logic [7:0] out_byte, next_out_byte;
   logic data_seen, next_data_seen;
   logic lock_bit_ok, next_lock_bit_ok;
   logic next_dout, next_dout_oe;
   logic at_boundary;
   logic write_ok;

   // Guards shared by page write and lock commands
   assign write_ok = WRITE_LATCH_FLAG && !timer_busy
                     && !(BLOCK_GUARD_HI && BLOCK_GUARD_LO);        // RL10
   assign at_boundary = (bit_cnt == 3'h0) && data_seen;

   always_comb begin
      next_state = state;
      next_shift = shift;
      next_bit_cnt = bit_cnt;
      next_addr_bytes = addr_bytes;
      next_opcode = opcode;
      next_lock_sel = lock_sel;
      next_addr = addr;
      next_out_byte = out_byte;
      next_data_seen = data_seen;
      next_lock_bit_ok = lock_bit_ok;
      next_dout = DOUT;
      next_dout_oe = DOUT_OE;
      if (!pins.sel) begin
         next_state = ST_IDLE;                                       // RL5
         next_dout_oe = 1'b0;
         next_dout = 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               next_state = ST_OPCODE;
               next_bit_cnt = 3'h0;
               next_addr_bytes = 2'h0;
               next_data_seen = 1'b0;
               next_lock_bit_ok = 1'b0;
            end
            ST_OPCODE, ST_ADDR, ST_DATA_IN: begin
               if (pins.clk_rise) begin
                  next_shift = {shift[6:0], pins.din};
                  next_bit_cnt = bit_cnt + 3'h1;
                  if (bit_cnt == 3'h7) begin
                     if (state == ST_OPCODE) begin
                        next_opcode = {shift[6:0], pins.din};
                        if (next_opcode == OP_READ_PAGE
                            || next_opcode == OP_WRITE_PAGE) begin    // RL23
                           next_state = ST_ADDR;
                        end else begin
                           next_state = ST_IGNORE;
                        end
                     end else if (state == ST_ADDR) begin
                        next_addr_bytes = addr_bytes + 2'h1;
                        if (addr_bytes == 2'h0) begin
                           next_lock_sel = shift[LOCK_REGION_BIT - 8 - 1]; // RL11 RL15
                        end else begin
                           next_addr = {shift[PAGE_ADDR_W-2:0], pins.din}; // RL2 RL7
                           if (opcode == OP_READ_PAGE) begin
                              if (timer_busy) begin
                                 next_state = ST_IGNORE;            // RL6 RL14
                              end else begin
                                 next_state = ST_DATA_OUT;
                                 next_out_byte = lock_sel ? {7'h0, lock_nv}  // RL12
                                    : read_byte({shift[PAGE_ADDR_W-2:0], pins.din});
                              end
                           end else begin
                              next_state = ST_DATA_IN;
                           end
                        end
                     end else begin
                        next_data_seen = 1'b1;
                        next_lock_bit_ok = shift[LOCK_DATA_BIT-1];  // RL16
                        if (!lock_sel) begin
                           next_addr = addr + 6'h1;
                        end
                     end
                  end
               end
            end
            ST_DATA_OUT: begin
               next_dout_oe = 1'b1;
               if (pins.clk_fall) begin
                  next_dout = out_byte[3'h7 - bit_cnt];             // RL2
                  next_bit_cnt = bit_cnt + 3'h1;
                  if (bit_cnt == 3'h7) begin
                     if (lock_sel) begin
                        next_out_byte = {7'h0, lock_nv};           // RL13
                     end else begin
                        next_addr = addr + 6'h1;                     // RL3 RL4
                        next_out_byte = read_byte(addr + 6'h1);
                     end
                  end
               end
            end
            ST_IGNORE: next_state = ST_IGNORE;
            default: next_state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         state <= ST_IDLE;                                           // RL19
         shift <= 8'h00;
         bit_cnt <= 3'h0;
         addr_bytes <= 2'h0;
         opcode <= 8'h00;
         lock_sel <= 1'b0;
         addr <= 6'h00;
         out_byte <= 8'h00;
         data_seen <= 1'b0;
         lock_bit_ok <= 1'b0;
         DOUT <= 1'b0;
         DOUT_OE <= 1'b0;
      end else begin
         state <= next_state;
         shift <= next_shift;
         bit_cnt <= next_bit_cnt;
         addr_bytes <= next_addr_bytes;
         opcode <= next_opcode;
         lock_sel <= next_lock_sel;
         addr <= next_addr;
         out_byte <= next_out_byte;
         data_seen <= next_data_seen;
         lock_bit_ok <= next_lock_bit_ok;
         DOUT <= next_dout;
         DOUT_OE <= next_dout_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write collection, start at select rise, commit at cycle end
   logic is_write, is_lock, take_write, take_lock;
   assign is_write = (state == ST_DATA_IN) && !lock_sel;
   assign is_lock = (state == ST_DATA_IN) && lock_sel;
   // Page data needs a whole byte; partial trailing bits are dropped
   assign take_write = pins.sel_rise && is_write && data_seen && write_ok
                       && !lock_nv;                                  // RL8 RL25
   assign take_lock = pins.sel_rise && is_lock && at_boundary && lock_bit_ok
                      && write_ok;                                   // RL17 RL18
   assign timer_start = take_write || take_lock;

   logic next_write_pending, next_lock_pending, next_lock_nv;
   logic next_latch_clear;
   logic [7:0] next_pend [GROUP_BYTES];
   logic [GROUP_BYTES-1:0] next_pend_mask;
   logic [PAGE_ADDR_W-1:0] byte_addr;
   assign byte_addr = addr;
   logic byte_in;
   // Staging frozen while a taken write waits for its commit
   assign byte_in = is_write && pins.clk_rise && (bit_cnt == 3'h7) && !write_pending;

   always_comb begin
      next_write_pending = write_pending;
      next_lock_pending = lock_pending;
      next_lock_nv = lock_nv;
      next_pend = pend;
      next_pend_mask = pend_mask;
      next_latch_clear = 1'b0;
      // Capture each completed data byte into the group staging, last wins
      if (byte_in) begin
         next_pend[byte_addr[1:0]] = {shift[6:0], pins.din};
         next_pend_mask[byte_addr[1:0]] = 1'b1;
      end
      if (state == ST_IDLE && pins.sel && !write_pending) begin
         next_pend_mask = '0;
      end
      if (take_write) next_write_pending = 1'b1;
      if (take_lock) next_lock_pending = 1'b1;
      if (timer_start) next_latch_clear = 1'b1;
      if (timer_done) begin
         next_write_pending = 1'b0;
         next_lock_pending = 1'b0;
         if (lock_pending) next_lock_nv = 1'b1;                      // RL18
      end
   end

   // The group address of the staged data is fixed by the last byte taken
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         write_pending <= 1'b0;
         lock_pending <= 1'b0;
         pend_mask <= '0;
         pend_addr <= 6'h00;
         LATCH_CLEAR <= 1'b0;
         for (int i = 0; i < GROUP_BYTES; i++) pend[i] <= 8'h00;
      end else begin
         write_pending <= next_write_pending;
         lock_pending <= next_lock_pending;
         pend_mask <= next_pend_mask;
         pend <= next_pend;
         LATCH_CLEAR <= next_latch_clear;
         if (byte_in) pend_addr <= byte_addr;
      end
   end

   // Whole group rewritten at cycle end, untouched bytes written back
   always_ff @(posedge CLOCK) begin
      lock_nv <= next_lock_nv;                                       // RL1
      if (timer_done && write_pending) begin
         for (int j = 0; j < GROUP_BYTES; j++) begin
            page[{group_of(pend_addr), 2'(j)}] <= pend_mask[j] ? pend[j]
               : page[{group_of(pend_addr), 2'(j)}];                 // RL21
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         WRITE_BUSY_FLAG <= 1'b0;
         PAGE_LOCKED <= 1'b0;
      end else begin
         WRITE_BUSY_FLAG <= timer_busy || timer_start;               // RL26
         PAGE_LOCKED <= lock_nv;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_lock_taken;
      take_lock;
   endsequence
   a_busy_after_start: assert property (@(posedge CLOCK) disable iff (!RST_N)
      timer_start |=> ##1 WRITE_BUSY_FLAG)                           // RL26
      else $error("busy not raised after start");
   a_no_start_busy: assert property (@(posedge CLOCK) disable iff (!RST_N)
      timer_start |-> !timer_busy)                                   // RL10
      else $error("write started while busy");
   a_guard_blocks: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (BLOCK_GUARD_HI && BLOCK_GUARD_LO) |-> !timer_start)           // RL10
      else $error("write started with both guards set");
   a_locked_no_write: assert property (@(posedge CLOCK) disable iff (!RST_N)
      lock_nv |-> !take_write)                                       // RL25
      else $error("page write accepted while locked");
   a_lock_boundary: assert property (@(posedge CLOCK) disable iff (!RST_N)
      s_lock_taken |-> bit_cnt == 3'h0 && lock_bit_ok)               // RL17
      else $error("lock accepted off a byte boundary");
   a_start_at_rise: assert property (@(posedge CLOCK) disable iff (!RST_N)
      timer_start |-> pins.sel_rise)                                 // RL8
      else $error("write cycle not started at select rise");
   a_deselect_quiet: assert property (@(posedge CLOCK) disable iff (!RST_N)
      !pins.sel |=> !DOUT_OE)                                        // RL5
      else $error("output driven while deselected");
   a_busy_no_read: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state == ST_ADDR && timer_busy) |=> state != ST_DATA_OUT)     // RL6
      else $error("read accepted during write cycle");
   a_lock_sticks: assert property (@(posedge CLOCK) disable iff (!RST_N)
      lock_nv |=> lock_nv)                                           // RL18
      else $error("lock flag cleared");

endmodule : eip_ident_page

// ==== eip_pkg.sv ====
// Package for the identification page command block of a serial EEPROM.
// Assumes one 200 MHz system clock; the serial link is sampled, not clocked on.
package eip_pkg;

   // Opcodes shared between page and lock operations
   localparam logic [7:0] OP_READ_PAGE = 8'h83;
   localparam logic [7:0] OP_WRITE_PAGE = 8'h82;

   // Address field positions
   localparam int LOCK_REGION_BIT = 10;
   localparam int PAGE_ADDR_W = 6;
   localparam int PAGE_BYTES = 64;
   localparam int LOCK_DATA_BIT = 1;
   localparam int GROUP_BYTES = 4;

   // Reset and delivery values
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [23:0] IDENT_CODE_DEFAULT = 24'h5a_a5_01; // Arbitrary value

   // Self-timed write time and its cycle count
   localparam int CLOCK_MHZ = 200;
   localparam int WRITE_TIME_US = 4000;
   localparam int WRITE_CYCLES = WRITE_TIME_US * CLOCK_MHZ;

   // Serial sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_OPCODE = 3'b001,
      ST_ADDR = 3'b010,
      ST_DATA_IN = 3'b011,
      ST_DATA_OUT = 3'b100,
      ST_IGNORE = 3'b101
   } eip_state_t;

endpackage : eip_pkg

// ==== eip_pin_if.sv ====
// Interface carrying the synchronised serial pins and the edges found on them.
// Assumes the synchroniser module drives it and the main module reads it.
interface eip_pin_if;
   logic sel;
   logic sel_rise;
   logic sel_fall;
   logic clk_rise;
   logic clk_fall;
   logic din;

   modport src (output sel, sel_rise, sel_fall, clk_rise, clk_fall, din);
   modport dst (input sel, sel_rise, sel_fall, clk_rise, clk_fall, din);
endinterface : eip_pin_if

// ==== eip_pin_sync.sv ====
// Two-flop synchronisers for the serial pins plus edge detection.
// Assumes pins are asynchronous to CLOCK and much slower than it.
module eip_pin_sync (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sel_n_pin,
   input wire logic sclk_pin,
   input wire logic din_pin,
   eip_pin_if.src pins
);
   import eip_pkg::*;

   logic [2:0] meta;
   logic [2:0] stable;
   logic [2:0] last;
   logic [2:0] next_meta;
   logic [2:0] next_stable;
   logic [2:0] next_last;

   ////////////////////////////////////////////////////////////////////////////
   // Next values; only the second and third stages feed the edge logic
   always_comb begin
      next_meta = {din_pin, sclk_pin, ~sel_n_pin};
      next_stable = meta;
      next_last = stable;
   end

   // Deselected idle value so no false select edge leaves reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         meta <= 3'h0;
         stable <= 3'h0;
         last <= 3'h0;
      end else begin
         meta <= next_meta;
         stable <= next_stable;
         last <= next_last;
      end
   end

   assign pins.sel = stable[0];
   assign pins.sel_rise = last[0] & ~stable[0];
   assign pins.sel_fall = ~last[0] & stable[0];
   assign pins.clk_rise = ~last[1] & stable[1];
   assign pins.clk_fall = last[1] & ~stable[1];
   assign pins.din = stable[2];

endmodule : eip_pin_sync

// ==== eip_write_timer.sv ====
// Self-timed write cycle timer; busy from start pulse for the write time.
// Assumes start is a one-cycle pulse from the same clock.
module eip_write_timer #(
   parameter int CYCLES = 800000
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic start,
   output logic busy,
   output logic done
);
   import eip_pkg::*;

   logic [31:0] count;
   logic [31:0] next_count;
   logic next_busy;
   logic next_done;

   ////////////////////////////////////////////////////////////////////////////
   // Count down; done pulses in the cycle busy falls
   always_comb begin
      next_count = count;
      next_busy = busy;
      next_done = 1'b0;
      if (start && !busy) begin
         next_count = 32'(CYCLES - 1);
         next_busy = 1'b1;
      end else if (busy) begin
         if (count == 32'h0) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end else begin
            next_count = count - 32'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         count <= 32'h0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         count <= next_count;
         busy <= next_busy;
         done <= next_done;
      end
   end

endmodule : eip_write_timer

// ==== eip_spi_master.sv ====
// Bus master model for the identification page block.
// Assumes the bench clock paces it; serial clock idles low between frames.
module eip_spi_master (
   // Bench clock
   input wire logic clk,
   // Serial pins
   output logic sel_n,
   output logic sclk,
   output logic din,
   input wire logic dout
);
   timeunit 1ns;
   timeprecision 100ps;
   // Deselected and quiet from time zero
   initial begin
      sel_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Half period of 16 cycles, pins move just after the edge
   task automatic hp();
      repeat (16) @(posedge clk);
      #1;
   endtask : hp
   // Select after a gap, so commands stay far enough apart
   task automatic start();
      hp();
      sel_n = 1'b0;
      hp();
   endtask : start
   // Bits go out MSB first; the released data line is inverted
   task automatic put(input logic [7:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         din = v[7 - i];
         hp();
         sclk = 1'b1;
         hp();
         sclk = 1'b0;
      end
      din = ~din;
   endtask : put
   // Sample before each rise, when output has long settled
   task automatic get(output logic [7:0] v, input int n);
      v = 8'h00;
      for (int i = 0; i < n; i++) begin
         hp();
         v[7 - i] = dout;
         sclk = 1'b1;
         hp();
         sclk = 1'b0;
      end
   endtask : get
   // Deselect, allowed mid-byte in a read
   task automatic stop();
      hp();
      sel_n = 1'b1;
      hp();
   endtask : stop
endmodule : eip_spi_master

// ==== tb.sv ====
// Self-checking bench for the identification page block.
// Assumes the master model paces frames; write latch is played by the bench.
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int WC = 2000; // Short write time keeps the run brief
   localparam logic [23:0] IDC = 24'h3c_69_0f; // Arbitrary value
   logic CLOCK, RST_N, SEL_N, SCLK, DIN, DOUT, DOUT_OE, WRITE_BUSY_FLAG;
   logic WRITE_LATCH_FLAG, BLOCK_GUARD_HI, BLOCK_GUARD_LO, LATCH_CLEAR, PAGE_LOCKED;
   int n_fail = 0, check_count = 0, busy_cnt = 0, lc_cnt = 0, oe_cnt = 0;
   logic [7:0] b;
   eip_ident_page #(.WRITE_CYCLES_P(WC), .IDENT_CODE(IDC)) dut (.CLOCK(CLOCK), .RST_N(RST_N),
      .SEL_N(SEL_N), .SCLK(SCLK), .DIN(DIN), .DOUT(DOUT), .DOUT_OE(DOUT_OE),
      .WRITE_LATCH_FLAG(WRITE_LATCH_FLAG), .BLOCK_GUARD_HI(BLOCK_GUARD_HI),
      .BLOCK_GUARD_LO(BLOCK_GUARD_LO), .WRITE_BUSY_FLAG(WRITE_BUSY_FLAG),
      .LATCH_CLEAR(LATCH_CLEAR), .PAGE_LOCKED(PAGE_LOCKED));
   eip_spi_master m (.clk(CLOCK), .sel_n(SEL_N), .sclk(SCLK), .din(DIN), .dout(DOUT));
   // 200 MHz clock
   initial begin
      CLOCK = 1'b0;
      forever #2.5 CLOCK = ~CLOCK;
   end
   // Cycle counts of busy, latch clear and output enable
   always @(posedge CLOCK) begin
      if (WRITE_BUSY_FLAG === 1'b1) busy_cnt++;
      if (LATCH_CLEAR === 1'b1) lc_cnt++;
      if (DOUT_OE === 1'b1) oe_cnt++;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_byte
   task automatic chk_flag(input string nm, input logic e, input logic g);
      chk_byte(nm, {7'h00, e}, {7'h00, g});
   endtask : chk_flag
   task automatic chk_count(input string nm, input int e, input int g);
      check_count++;
      if (g != e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chk_count
   ////////////////////////////////////////////////////////////////////////////
   // Opcode and two address bytes
   task automatic cmd(input logic [7:0] op, input logic [15:0] a);
      m.start();
      m.put(op, 8);
      m.put(a[15:8], 8);
      m.put(a[7:0], 8);
   endtask : cmd
   // Write frame with nb data bits; counters cleared first
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input int nb);
      busy_cnt = 0;
      lc_cnt = 0;
      oe_cnt = 0;
      cmd(8'h82, a);
      m.put(d[15:8], nb > 8 ? 8 : nb);
      if (nb > 8) m.put(d[7:0], nb - 8);
      m.stop();
   endtask : wr
   task automatic read_chk(input logic [15:0] a, input logic [31:0] e, input int n);
      cmd(8'h83, a);
      for (int k = 0; k < n; k++) begin
         m.get(b, 8);
         chk_byte("page byte", e[31 - 8 * k -: 8], b);
      end
      m.stop();
   endtask : read_chk
   // Lock state byte twice in one frame
   task automatic ls_chk(input logic e);
      cmd(8'h83, 16'h0400);
      repeat (2) begin
         m.get(b, 8);
         chk_flag("lock bit", e, b[0]);
      end
      m.stop();
   endtask : ls_chk
   // Bounded wait for the end of a timed write
   task automatic wait_idle();
      int k;
      for (k = 0; k < WC + 200 && WRITE_BUSY_FLAG !== 1'b0; k++) @(posedge CLOCK);
      #1;
      chk_flag("busy ends", 1'b0, WRITE_BUSY_FLAG);
      if (WRITE_BUSY_FLAG !== 1'b0) print_verdict();
   endtask : wait_idle
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk_flag("busy", 1'b0, WRITE_BUSY_FLAG);
      chk_flag("output enable", 1'b0, DOUT_OE);
      chk_flag("latch clear", 1'b0, LATCH_CLEAR);
      chk_flag("locked", 1'b0, PAGE_LOCKED);
      $display("test reset done");
   endtask : t_reset
   task automatic t_read();
      read_chk(16'h0000, {IDC, 8'hff}, 4);
      read_chk(16'h003e, 32'hffff_0000, 2);
      cmd(8'h83, 16'h0020);
      m.get(b, 3);
      m.stop();
      chk_flag("output enable", 1'b0, DOUT_OE);
      $display("test read done");
   endtask : t_read
   task automatic t_write();
      WRITE_LATCH_FLAG = 1'b1;
      wr(16'h0005, 16'ha73c, 16);
      WRITE_LATCH_FLAG = 1'b0;
      cmd(8'h83, 16'h0004);
      m.get(b, 8);
      m.stop();
      chk_count("output during write", 0, oe_cnt);
      wait_idle();
      // Flag rises with the start pulse, then stands for the timed count
      chk_count("busy cycles", WC + 1, busy_cnt);
      chk_count("latch clears", 1, lc_cnt);
      read_chk(16'h0004, 32'hffa7_3cff, 4);
      WRITE_LATCH_FLAG = 1'b1;
      wr(16'h0001, 16'h0000, 8);
      WRITE_LATCH_FLAG = 1'b0;
      wait_idle();
      read_chk(16'h0000, {IDC[23:16], 8'h00, IDC[7:0], 8'hff}, 4);
      $display("test write done");
   endtask : t_write
   task automatic t_refuse();
      logic [15:0] ad [6] = '{16'h0010, 16'h0010, 16'h0400, 16'h0400, 16'h0400, 16'h0010};
      logic [7:0] dv [6] = '{8'h11, 8'h11, 8'h02, 8'hfd, 8'h02, 8'h11};
      int nb [6] = '{8, 8, 8, 8, 5, 0};
      logic lt [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      logic gd [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      for (int i = 0; i < 6; i++) begin
         WRITE_LATCH_FLAG = lt[i];
         BLOCK_GUARD_HI = gd[i];
         BLOCK_GUARD_LO = gd[i];
         wr(ad[i], {dv[i], 8'h00}, nb[i]);
         chk_count("busy when refused", 0, busy_cnt);
      end
      WRITE_LATCH_FLAG = 1'b0;
      BLOCK_GUARD_HI = 1'b0;
      BLOCK_GUARD_LO = 1'b0;
      chk_flag("locked", 1'b0, PAGE_LOCKED);
      read_chk(16'h0010, 32'hff00_0000, 1);
      $display("test refuse done");
   endtask : t_refuse
   task automatic t_lock();
      ls_chk(1'b0);
      WRITE_LATCH_FLAG = 1'b1;
      wr(16'h04ff, 16'hfe00, 8);
      WRITE_LATCH_FLAG = 1'b0;
      cmd(8'h83, 16'h0400);
      m.get(b, 8);
      m.stop();
      chk_count("status during write", 0, oe_cnt);
      wait_idle();
      chk_count("lock busy cycles", WC + 1, busy_cnt);
      chk_flag("locked", 1'b1, PAGE_LOCKED);
      ls_chk(1'b1);
      WRITE_LATCH_FLAG = 1'b1;
      wr(16'h0008, 16'h5500, 8);
      WRITE_LATCH_FLAG = 1'b0;
      chk_count("busy when locked", 0, busy_cnt);
      read_chk(16'h0008, 32'hff00_0000, 1);
      $display("test lock done");
   endtask : t_lock
   ////////////////////////////////////////////////////////////////////////////
   // Reset for four cycles, then the scenarios in order
   initial begin
      RST_N = 1'b0;
      WRITE_LATCH_FLAG = 1'b0;
      BLOCK_GUARD_HI = 1'b0;
      BLOCK_GUARD_LO = 1'b0;
      repeat (4) @(posedge CLOCK);
      #1;
      RST_N = 1'b1;
      repeat (4) @(posedge CLOCK);
      #1;
      t_reset();
      t_read();
      t_write();
      t_refuse();
      t_lock();
      print_verdict();
   end
endmodule : tb
